// ### hw/plr_link_req.sv
// phy side link request decoder, ctl driver and pending request tracker
// Operation
// - phy ctl codes: 00 idle, 01 status, 10 receive, 11 grant.
// - requests arrive serially on lreq; lengths 6, 7, 9, 17 bits.
// - each request starts with a one bit and ends with a zero stop bit.
// - bus request: type bits 1-3, speed bits 4-5; speed 11 reserved.
// - register read: type bits 1-3, address bits 4-7, stop bit 8.
// - register write: address bits 4-7, data bits 8-15, stop bit 16.
// - acceleration control bit 4 disables (0) or enables (1) acceleration.
// - type codes: imm, iso, pri, fair, read, write, accel, reserved.
// - receive starting during or after fair/priority request cancels it.
// - with acceleration on, an 8-bit ack receive keeps fair/priority pending.
// - pending iso cleared only by grant, subaction gap or bus reset.
// - addressed register updates as soon as write's last bit arrives.
// - read returns register as status; interrupted status restarts from bit 0.
// - further bus requests ignored while one pends; listed events end it.
// - bus reset discards every pending bus request.
// - iso request sets the internal accelerating flag.
// - status holds ctl 01 throughout, two status bits per clock on d.
// - arbitration win drives grant one clock then idle two clocks.
`timescale 1ns/1ps
`include "plr_defs.svh"
module plr_link_req
  import plr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic lreq,
  input wire logic rx_active,
  input wire logic rx_ack8,
  input wire logic tx_active,
  input wire logic arb_won,
  input wire logic subaction_gap,
  input wire logic bus_reset,
  output logic [1:0] ctl_o,
  output logic [1:0] d_o,
  output logic req_pending,
  output logic [2:0] req_type,
  output logic [1:0] req_speed,
  output logic accel_enable,
  output logic accelerating
);
  // register memory sits behind the bundle; its read data lag one clock
  plr_reg_if rif ();
  plr_regmem u_mem (
    .clk_sys(clk_sys),
    .rif(rif)
  );

  // lreq is a pin: two flops before any logic
  logic lreq_s1_q, lreq_s2_q;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      lreq_s1_q <= 1'b0;
      lreq_s2_q <= 1'b0;
    end else begin
      lreq_s1_q <= lreq;
      lreq_s2_q <= lreq_s1_q;
    end
  end

  // ---------------- serial receiver ----------------
  logic busy_q, busy_d;
  logic [4:0] cnt_q, cnt_d;
  logic [16:0] sh_q, sh_d;
  logic [2:0] ty_q, ty_d;
  logic done;
  logic [16:0] frame;
  logic [4:0] want_len;
  plr_rq_t rtype;

  // expected length follows the type once bits 1..3 are in
  // the type is latched because the shifter moves on past it
  always_comb begin
    rtype = plr_rq_t'(ty_q);
    unique case (rtype)
      PLR_RQ_RD: want_len = `PLR_LEN_RD;
      PLR_RQ_WR: want_len = `PLR_LEN_WR;
      PLR_RQ_ACC: want_len = `PLR_LEN_ACC;
      default: want_len = `PLR_LEN_BUS;
    endcase
  end

  // shift in msb first: bit 1 ends up oldest; the stop bit lands at frame index 0
  always_comb begin
    busy_d = busy_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ty_d = ty_q;
    done = 1'b0;
    frame = 17'h00000;
    if (!busy_q) begin
      if (lreq_s2_q) begin
        busy_d = 1'b1;
        cnt_d = 5'd1;
        sh_d = 17'h00000;
      end
    end else begin
      sh_d = {sh_q[15:0], lreq_s2_q};
      cnt_d = cnt_q + 5'd1;
      // bits 1..3 are all in once the count reaches four
      if (cnt_q == 5'd4) begin
        ty_d = sh_q[2:0];
      end
      // final bit arrives when count reaches length-1 (type known by then)
      // a one in the stop position drops the whole frame
      if (cnt_q >= 5'd4 && cnt_q == want_len - 5'd1) begin
        busy_d = 1'b0;
        done = !lreq_s2_q;
        frame = sh_d;
      end
    end
  end

  // receiver state registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      cnt_q <= 5'h00;
      sh_q <= 17'h00000;
      ty_q <= 3'h0;
    end else begin
      busy_q <= busy_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ty_q <= ty_d;
    end
  end

  // field extraction: frame bit k (k>=1) sits at index (len-1-k)
  logic [2:0] f_type;
  logic [1:0] f_speed;
  logic [3:0] f_addr;
  logic [7:0] f_data;
  logic f_acc;
  always_comb begin
    f_type = ty_q;
    f_speed = frame[2:1];
    f_addr = rtype == PLR_RQ_WR ? frame[12:9] : frame[4:1];
    f_data = frame[8:1];
    f_acc = frame[1];
  end
  // only the four bus request types with a legal speed may become pending
  logic is_bus;
  assign is_bus = done && (f_type <= 3'h3) && (f_speed != 2'h3);

  // ---------------- pending bus request and acceleration ----------------
  logic pend_q, pend_d;
  logic [2:0] ptype_q, ptype_d;
  logic [1:0] pspd_q, pspd_d;
  logic acc_en_q, acc_en_d;
  logic accing_q, accing_d;
  logic rx_q;
  logic rx_cut_q, rx_cut_d;
  logic cut_now;
  logic rx_start;
  logic grant_now;
  assign rx_start = rx_active && !rx_q;

  always_comb begin
    pend_d = pend_q;
    ptype_d = ptype_q;
    pspd_d = pspd_q;
    acc_en_d = acc_en_q;
    accing_d = accing_q;
    // a receive that starts while a fair or priority frame is still arriving
    // cancels it too, so the decoded frame must not become pending
    rx_cut_d = busy_q && (rx_cut_q || (rx_start && !(acc_en_q && rx_ack8)));
    cut_now = rx_cut_d && (f_type == PLR_RQ_FAIR || f_type == PLR_RQ_PRI);
    if (done && f_type == PLR_RQ_ACC) begin
      acc_en_d = f_acc;
    end
    if (pend_q) begin
      // fair/pri cancelled by receive unless ack accelerated
      if (rx_start && (ptype_q == PLR_RQ_FAIR || ptype_q == PLR_RQ_PRI)
          && !(acc_en_q && rx_ack8)) begin
        pend_d = 1'b0;
      end
      if ((tx_active || rx_start) && ptype_q != PLR_RQ_ISO
          && ptype_q != PLR_RQ_FAIR && ptype_q != PLR_RQ_PRI) begin
        pend_d = 1'b0;
      end
      if (subaction_gap && (ptype_q == PLR_RQ_ISO || ptype_q == PLR_RQ_IMM)) begin
        pend_d = 1'b0;
      end
      if (grant_now) begin
        pend_d = 1'b0;
      end
    end else if (is_bus && !cut_now) begin
      pend_d = 1'b1; // later bus requests ignored while pending
      ptype_d = f_type;
      pspd_d = f_speed;
      if (f_type == PLR_RQ_ISO) begin
        accing_d = 1'b1;
      end
    end
    if (bus_reset) begin
      pend_d = 1'b0;
    end
  end

  // pending request and acceleration registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pend_q <= 1'b0;
      ptype_q <= 3'h0;
      pspd_q <= 2'h0;
      acc_en_q <= `PLR_ACCEL_RST;
      accing_q <= 1'b0;
      rx_q <= 1'b0;
      rx_cut_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      ptype_q <= ptype_d;
      pspd_q <= pspd_d;
      acc_en_q <= acc_en_d;
      accing_q <= accing_d;
      rx_q <= rx_active;
      rx_cut_q <= rx_cut_d;
    end
  end

  // ---------------- register access ----------------
  // write lands the same cycle the stop bit is taken
  assign rif.we = done && f_type == PLR_RQ_WR;
  assign rif.waddr = f_addr;
  assign rif.wdata = f_data;

  // ---------------- ctl / status engine ----------------
  plr_state_t st_q, st_d;
  logic rd_pend_q, rd_pend_d;
  logic [3:0] raddr_q, raddr_d;
  logic [15:0] stat_q, stat_d;
  logic [2:0] scnt_q, scnt_d;
  logic load_wait_q, load_wait_d;
  logic [1:0] ctl_d, d_d;
  logic [1:0] ctl_q, d_q;
  logic pkt;
  // packet activity in either direction holds off status and grant
  assign pkt = rx_active || tx_active;
  assign rif.raddr = raddr_q;
  // no grant during a packet: the link would clash with receive data
  assign grant_now = st_q == PLR_ST_IDLE && arb_won && pend_q && !pkt;

  always_comb begin
    st_d = st_q;
    rd_pend_d = rd_pend_q;
    raddr_d = raddr_q;
    stat_d = stat_q;
    scnt_d = scnt_q;
    load_wait_d = 1'b0;
    ctl_d = PLR_CTL_IDLE;
    d_d = 2'h0;
    unique case (st_q)
      PLR_ST_IDLE: begin
        if (rx_active) begin
          ctl_d = PLR_CTL_RECEIVE;
        end else if (grant_now) begin
          st_d = PLR_ST_GRANT;
          ctl_d = PLR_CTL_GRANT;
        end else if (rd_pend_q && !load_wait_q && !tx_active) begin
          st_d = PLR_ST_STAT;
          stat_d = {4'h0, raddr_q, rif.rdata};
          scnt_d = 3'h0;
          ctl_d = PLR_CTL_STATUS;
          d_d = 2'h0;
        end
      end
      PLR_ST_STAT: begin
        if (pkt) begin
          // interrupted: restart from the first bit later
          st_d = PLR_ST_IDLE;
          ctl_d = rx_active ? PLR_CTL_RECEIVE : PLR_CTL_IDLE;
        end else if (scnt_q == 3'h7) begin
          st_d = PLR_ST_IDLE;
          rd_pend_d = 1'b0;
        end else begin
          scnt_d = scnt_q + 3'h1;
          stat_d = {stat_q[13:0], 2'h0};
          ctl_d = PLR_CTL_STATUS;
          d_d = stat_d[15:14];
        end
      end
      PLR_ST_GRANT: begin
        st_d = PLR_ST_GIDLE;
      end
      PLR_ST_GIDLE: begin
        // link owns ctl afterwards; it must not use 11
        st_d = PLR_ST_IDLE;
      end
    endcase
    // taken after the state case so a new read outranks the end of the old one
    if (done && f_type == PLR_RQ_RD) begin
      rd_pend_d = 1'b1;
      raddr_d = f_addr;
      load_wait_d = 1'b1; // memory read data is one cycle late
    end
    if (bus_reset) begin
      st_d = PLR_ST_IDLE;
      rd_pend_d = 1'b0;
      ctl_d = PLR_CTL_IDLE;
      d_d = 2'h0;
    end
  end

  // ctl engine registers; ctl and d leave straight from here
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_q <= PLR_ST_IDLE;
      rd_pend_q <= 1'b0;
      raddr_q <= 4'h0;
      stat_q <= 16'h0000;
      scnt_q <= 3'h0;
      load_wait_q <= 1'b0;
      ctl_q <= 2'h0;
      d_q <= 2'h0;
    end else begin
      st_q <= st_d;
      rd_pend_q <= rd_pend_d;
      raddr_q <= raddr_d;
      stat_q <= stat_d;
      scnt_q <= scnt_d;
      load_wait_q <= load_wait_d;
      ctl_q <= ctl_d;
      d_q <= d_d;
    end
  end

  // all outputs straight from flops
  assign ctl_o = ctl_q;
  assign d_o = d_q;
  assign req_pending = pend_q;
  assign req_type = ptype_q;
  assign req_speed = pspd_q;
  assign accel_enable = acc_en_q;
  assign accelerating = accing_q;
endmodule // plr_link_req

// ### hw/plr_defs.svh
// constants for the phy side link request interpreter
`ifndef PLR_DEFS_SVH
`define PLR_DEFS_SVH
`define PLR_LEN_ACC 5'd6
`define PLR_LEN_BUS 5'd7
`define PLR_LEN_RD 5'd9
`define PLR_LEN_WR 5'd17
`define PLR_STAT_BITS 5'd16
`define PLR_ACCEL_RST 1'b0
`define PLR_REGS 16
`endif

// ### hw/plr_pkg.sv
// types for the phy side link request interpreter
package plr_pkg;
  typedef enum logic [1:0] {
    PLR_CTL_IDLE = 2'h0,
    PLR_CTL_STATUS = 2'h1,
    PLR_CTL_RECEIVE = 2'h2,
    PLR_CTL_GRANT = 2'h3
  } plr_ctl_t;
  typedef enum logic [2:0] {
    PLR_RQ_IMM = 3'h0,
    PLR_RQ_ISO = 3'h1,
    PLR_RQ_PRI = 3'h2,
    PLR_RQ_FAIR = 3'h3,
    PLR_RQ_RD = 3'h4,
    PLR_RQ_WR = 3'h5,
    PLR_RQ_ACC = 3'h6,
    PLR_RQ_RSV = 3'h7
  } plr_rq_t;
  typedef enum logic [3:0] {
    PLR_ST_IDLE = 4'h1,
    PLR_ST_STAT = 4'h2,
    PLR_ST_GRANT = 4'h4,
    PLR_ST_GIDLE = 4'h8
  } plr_state_t;
endpackage

// ### hw/plr_reg_if.sv
// register file access bundle between the interpreter and its register memory
`timescale 1ns/1ps
interface plr_reg_if;
  logic we;
  logic [3:0] waddr;
  logic [7:0] wdata;
  logic [3:0] raddr;
  logic [7:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ### hw/plr_regmem.sv
// sixteen byte phy register memory with registered read data
`timescale 1ns/1ps
`include "plr_defs.svh"
module plr_regmem (
  input wire logic clk_sys,
  plr_reg_if.mem rif
);
  logic [7:0] mem_q [`PLR_REGS];
  logic [7:0] rdata_q;
  // no reset on the array; contents are defined by the first write
  always_ff @(posedge clk_sys) begin
    if (rif.we) begin
      mem_q[rif.waddr] <= rif.wdata;
    end
    rdata_q <= mem_q[rif.raddr];
  end
  assign rif.rdata = rdata_q;
endmodule // plr_regmem

// ### verif/plr_link_model.sv
// link side model that serialises requests onto the request line
`timescale 1ns/1ps
module plr_link_model (
  input wire logic clk_sys,
  output logic lreq
);
  initial lreq = 1'b0;
  // the model never drives ctl, so the reserved link code cannot occur
  // no crc errors are modelled, so a granted transfer is never withdrawn
  // frame is left aligned, bit 0 first, one bit per clock
  // every frame ends on its zero stop bit, so the line rests low between frames
  task automatic send(input logic [16:0] f, input logic [4:0] n);
    for (int i = 0; i < n; i++) begin
      lreq = f[16 - i];
      @(posedge clk_sys);
      #2;
    end
  endtask
endmodule // plr_link_model

// ### verif/plr_link_req_sva.sv
// port level assertions for the link request interpreter
`timescale 1ns/1ps
module plr_link_req_chk
  import plr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic rx_active,
  input wire logic tx_active,
  input wire logic arb_won,
  input wire logic subaction_gap,
  input wire logic bus_reset,
  input wire logic [1:0] ctl_o,
  input wire logic req_pending,
  input wire logic [2:0] req_type,
  input wire logic accelerating
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // sixteen status bits at two per clock, then the code leaves status
  sequence s_stat;
    (ctl_o == PLR_CTL_STATUS)[*8] ##1 (ctl_o != PLR_CTL_STATUS);
  endsequence
  sequence s_grant;
    (ctl_o == PLR_CTL_GRANT) ##1 (ctl_o == PLR_CTL_IDLE);
  endsequence
  chk_grant_then_idle: assert property ((ctl_o == PLR_CTL_GRANT) |-> s_grant)
    else $error("grant not followed by idle");
  chk_grant_needs_req: assert property ((ctl_o == PLR_CTL_GRANT) |-> $past(req_pending) && $past(arb_won))
    else $error("grant without won pending request");
  chk_receive_code: assert property (rx_active |=> ctl_o == PLR_CTL_RECEIVE)
    else $error("receive code missing");
  // a packet or a bus reset may cut the status short; anything else must run the full length
  chk_status_len: assert property ($rose(ctl_o == PLR_CTL_STATUS)
    |-> (s_stat or ##[0:8] (rx_active || tx_active || bus_reset)))
    else $error("status length wrong");
  chk_accel_sticky: assert property (accelerating |=> accelerating)
    else $error("accelerating flag dropped");
  chk_reset_clears: assert property (bus_reset |=> !req_pending)
    else $error("pending request survived bus reset");
  chk_iso_kept: assert property (req_pending && req_type == PLR_RQ_ISO && !arb_won
    && !subaction_gap && !bus_reset |=> req_pending)
    else $error("isochronous request lost");
  chk_type_held: assert property (req_pending ##1 req_pending |-> $stable(req_type))
    else $error("pending request replaced");
endmodule // plr_link_req_chk
bind plr_link_req plr_link_req_chk plr_link_req_chk_inst (.clk_sys(clk_sys), .nrst(nrst),
  .rx_active(rx_active), .tx_active(tx_active), .arb_won(arb_won), .bus_reset(bus_reset),
  .subaction_gap(subaction_gap), .ctl_o(ctl_o), .req_pending(req_pending),
  .req_type(req_type), .accelerating(accelerating));

// ### verif/plr_link_req_test.sv
// self-checking bench for the link request interpreter
`timescale 1ns/1ps
module plr_link_req_test
  import plr_pkg::*;
;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic lreq;
  logic rx_active = 1'b0;
  logic rx_ack8 = 1'b0;
  logic tx_active = 1'b0;
  logic arb_won = 1'b0;
  logic subaction_gap = 1'b0;
  logic bus_reset = 1'b0;
  logic [1:0] ctl_o;
  logic [1:0] d_o;
  logic req_pending;
  logic [2:0] req_type;
  logic [1:0] req_speed;
  logic accel_enable;
  logic accelerating;
  int fails = 0;
  int compares = 0;
  always #12.5 clk_sys = ~clk_sys;
  plr_link_req plr_link_req_inst (.clk_sys(clk_sys), .nrst(nrst), .lreq(lreq),
    .rx_active(rx_active), .rx_ack8(rx_ack8), .tx_active(tx_active), .arb_won(arb_won),
    .subaction_gap(subaction_gap), .bus_reset(bus_reset), .ctl_o(ctl_o), .d_o(d_o),
    .req_pending(req_pending), .req_type(req_type), .req_speed(req_speed),
    .accel_enable(accel_enable), .accelerating(accelerating));
  plr_link_model plr_link_model_inst (.clk_sys(clk_sys), .lreq(lreq));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // inputs always move 2 ns after the edge so the design samples them cleanly
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic tx(input logic [16:0] f, input logic [4:0] n);
    plr_link_model_inst.send(f, n);
  endtask
  // bounded wait for the status code; a hang here ends the run
  task automatic wait_stat();
    int i;
    for (i = 0; i < 12 && ctl_o !== PLR_CTL_STATUS; i++) step(1);
    if (i == 12) begin
      fails++;
      final_report();
    end
  endtask
  // collect the 16 status bits two per clock and compare whole
  task automatic read_stat(input logic [3:0] a, input logic [7:0] v);
    logic [15:0] st;
    wait_stat();
    for (int i = 0; i < 8; i++) begin
      st = {st[13:0], d_o};
      step(1);
    end
    check(st, {4'h0, a, v});
    check(16'(ctl_o), 16'(PLR_CTL_IDLE));
  endtask
  // write then read back to back, second read cut by a packet
  // each read completes before the next read is sent
  task automatic s_regs();
    tx({1'b1, PLR_RQ_WR, 4'hA, 8'h5C, 1'b0}, 5'd17);
    tx({1'b1, PLR_RQ_RD, 4'hA, 9'h0}, 5'd9);
    read_stat(4'hA, 8'h5C);
    tx({1'b1, PLR_RQ_WR, 4'h3, 8'hA5, 1'b0}, 5'd17);
    tx({1'b1, PLR_RQ_RD, 4'h3, 9'h0}, 5'd9);
    wait_stat();
    step(3);
    rx_active = 1'b1;
    step(2);
    check(16'(ctl_o), 16'(PLR_CTL_RECEIVE));
    rx_active = 1'b0;
    read_stat(4'h3, 8'hA5);
  endtask
  task automatic s_accel(input logic en);
    tx({1'b1, PLR_RQ_ACC, en, 1'b0, 11'h0}, 5'd6);
    step(5);
    check(16'(accel_enable), 16'(en));
  endtask
  // each bus request type is ended by a different event
  task automatic s_bus();
    plr_rq_t t;
    for (int i = 0; i < 4; i++) begin
      t = plr_rq_t'(i);
      tx({1'b1, t, 2'(i % 3), 1'b0, 10'h0}, 5'd7);
      tx({1'b1, PLR_RQ_FAIR, 2'h1, 1'b0, 10'h0}, 5'd7);
      step(5);
      check(16'(req_pending), 16'h1);
      check(16'(req_type), 16'(t));
      check(16'(req_speed), 16'(i % 3));
      if (i == 1) check(16'(accelerating), 16'h1);
      // a receive leaves isochronous pending and clears priority; fair survives an ack with acceleration on
      if (i != 0) begin
        rx_active = 1'b1;
        rx_ack8 = (i == 3);
        step(3);
        {rx_active, rx_ack8} = 2'h0;
        step(2);
        check(16'(req_pending), 16'(i != 2));
      end
      case (i)
        0: tx_active = 1'b1;
        1: begin
          arb_won = 1'b1;
          step(1);
          check(16'(ctl_o), 16'(PLR_CTL_GRANT));
          arb_won = 1'b0;
          step(1);
          check(16'(ctl_o), 16'(PLR_CTL_IDLE));
        end
        3: bus_reset = 1'b1;
        default: ;
      endcase
      step(2);
      {tx_active, bus_reset} = 2'h0;
      step(2);
      check(16'(req_pending), 16'h0);
    end
  endtask
  // a subaction gap ends isochronous and immediate requests, never a fair one
  task automatic s_gap();
    for (int i = 0; i < 3; i++) begin
      rx_active = 1'b1;
      step(2);
      rx_active = 1'b0;
      step(2); // ctl idle a full clock before the request
      tx({1'b1, 3'(i == 2 ? 3 : i), 2'h1, 1'b0, 10'h0}, 5'd7);
      step(5);
      check(16'(req_pending), 16'h1);
      subaction_gap = 1'b1;
      step(1);
      subaction_gap = 1'b0;
      step(1);
      check(16'(req_pending), 16'(i == 2));
      bus_reset = 1'b1;
      step(1);
      bus_reset = 1'b0;
      step(1);
    end
  endtask
  // reserved type and reserved speed leave everything untouched
  task automatic s_rsv();
    tx({1'b1, PLR_RQ_RSV, 2'h0, 1'b0, 10'h0}, 5'd7);
    tx({1'b1, PLR_RQ_PRI, 2'h3, 1'b0, 10'h0}, 5'd7);
    step(5);
    check(16'(req_pending), 16'h0);
    check(16'(ctl_o), 16'(PLR_CTL_IDLE));
  endtask
  initial begin
    step(4);
    check(16'({ctl_o, req_pending, accelerating, accel_enable}), 16'h0);
    nrst = 1'b1;
    step(1);
    s_regs();
    s_accel(1'b1);
    s_bus();
    s_gap();
    s_rsv();
    s_accel(1'b0);
    final_report();
  end
endmodule // plr_link_req_test
